// file: core/ebps_cfg.svh
// constants for the external bus pin strobe block
`ifndef EBPS_CFG_SVH
`define EBPS_CFG_SVH
`define EBPS_STB_CYC 4'h3
`define EBPS_CNT_ZERO 4'h0
`define EBPS_CNT_ONE 4'h1
`define EBPS_LANE_LO 0
`define EBPS_LANE_HI 1
`define EBPS_MUX_W 16
`define EBPS_SYNC_OLD 2
`define EBPS_SYNC_NEW 1
`endif

// file: core/ebps_pkg.sv
// types shared by the external bus pin strobe block
package ebps_pkg;
  // link-side sequencer states, one-hot
  typedef enum logic [3:0] {
    EBPS_IDLE = 4'h1,
    EBPS_ADDR = 4'h2,
    EBPS_STRB = 4'h4,
    EBPS_RECV = 4'h8
  } ebps_state_t;
endpackage

// file: core/ebps_core.sv
// external bus interface: request crossing, strobe sequencer and pin drivers
// Notes on behaviour
// - read strobe low while a read runs
// - single mode: write strobe low during writes
// - byte mode: per-lane store strobe on writes
// - single mode: lane enables on every access
// - multiplexed bus pulses the address latch
// - low wait input stretches the access
// - only the accessed area select goes low
// - bus clock is driven out on a pin
`include "ebps_cfg.svh"
module ebps_core
  import ebps_pkg::*;
#(
  parameter int AW = 24, // address width
  parameter int DW = 16, // data width, two byte lanes
  parameter int NAREA = 8 // number of area selects
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic en,
  input wire logic bus_clk,
  input wire logic req,
  output logic ready,
  input wire logic req_we,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  input wire logic [2:0] req_area,
  input wire logic byte_strobe_mode,
  input wire logic mux_mode,
  output logic done,
  output logic [DW-1:0] rdata,
  output logic ext_bus_clock_out,
  output logic rd_n,
  output logic wr_n,
  output logic low_lane_store_strobe_n,
  output logic high_lane_store_strobe_n,
  output logic low_lane_enable_n,
  output logic high_lane_enable_n,
  output logic ale,
  input wire logic wait_n,
  output logic [NAREA-1:0] area_select_n,
  output logic [AW-1:0] addr_out,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic [DW-1:0] data_in
);

  // the lane logic and the shared address lines assume exactly this shape
  if (AW != 24 || DW != `EBPS_MUX_W || NAREA != 8) begin : g_bad_shape
    $error("ebps_core: unsupported AW, DW or NAREA");
  end

  // one-hot area decode, used for the area select pins
  function automatic logic [NAREA-1:0] area_dec(input logic [2:0] a);
    logic [NAREA-1:0] r;
    r = '0;
    r[a] = 1'b1;
    return r;
  endfunction

  // system-side state
  typedef struct packed {
    logic req_tgl; // flips once per accepted request
    logic busy; // command held for the link side
    logic we;
    logic bmode;
    logic mux;
    logic [1:0] lanes;
    logic [2:0] area;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [2:0] done_s; // done toggle synchroniser plus edge stage
    logic done;
    logic [DW-1:0] rdata;
  } ebps_sys_t;

  // link-side state
  typedef struct packed {
    ebps_state_t st;
    logic [2:0] req_s; // request toggle synchroniser plus edge stage
    logic [1:0] en_s; // clock enable brought across
    logic [1:0] wt_s; // wait pin synchroniser
    logic [DW-1:0] din_s1;
    logic [DW-1:0] din_s2;
    logic we;
    logic bmode;
    logic mux;
    logic [1:0] lanes;
    logic [2:0] area;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [3:0] cnt; // strobe cycles still to run
    logic done_tgl;
    logic [DW-1:0] rdata;
    logic rd_n;
    logic wr_n;
    logic [1:0] store_n;
    logic [1:0] lane_n;
    logic ale;
    logic [NAREA-1:0] sel_n;
    logic [AW-1:0] aout;
    logic [DW-1:0] dout;
    logic doe;
  } ebps_link_t;

  ebps_sys_t s;
  ebps_sys_t next_s;
  ebps_link_t b;
  ebps_link_t next_b;
  logic [1:0] srst; // system reset release stages
  logic [1:0] brst; // link reset release stages
  logic srst_n;
  logic brst_n;

  // reset release, one chain per domain; assertion stays asynchronous
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srst <= 2'h0;
    end else begin
      srst <= {srst[0], 1'b1};
    end
  end

  always_ff @(posedge bus_clk or negedge resetn) begin
    if (!resetn) begin
      brst <= 2'h0;
    end else begin
      brst <= {brst[0], 1'b1};
    end
  end

  assign srst_n = srst[1];
  assign brst_n = brst[1];

  // system side: take a request, hold it, wait for the link to finish
  always_comb begin
    next_s = s;
    if (en) begin
      next_s.done = 1'b0;
      next_s.done_s = {s.done_s[1:0], b.done_tgl};
      if (req && !s.busy) begin
        next_s.req_tgl = ~s.req_tgl;
        next_s.busy = 1'b1;
        next_s.we = req_we;
        next_s.bmode = byte_strobe_mode;
        next_s.mux = mux_mode;
        next_s.lanes = req_lanes;
        next_s.area = req_area;
        next_s.addr = req_addr;
        next_s.wdata = req_wdata;
      end
      // completion edge: the link's read data is stable by now
      if (s.done_s[`EBPS_SYNC_OLD] ^ s.done_s[`EBPS_SYNC_NEW]) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.rdata = b.rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // link side: sequencer and registered pin values
  always_comb begin
    next_b = b;
    next_b.en_s = {b.en_s[0], en};
    if (b.en_s[1]) begin
      next_b.req_s = {b.req_s[1:0], s.req_tgl};
      next_b.wt_s = {b.wt_s[0], wait_n};
      next_b.din_s1 = data_in;
      next_b.din_s2 = b.din_s1;
      unique case (b.st)
        EBPS_IDLE: begin
          // command words are held steady while the toggle crosses
          if (b.req_s[`EBPS_SYNC_OLD] ^ b.req_s[`EBPS_SYNC_NEW]) begin
            next_b.we = s.we;
            next_b.bmode = s.bmode;
            next_b.mux = s.mux;
            next_b.lanes = s.lanes;
            next_b.area = s.area;
            next_b.addr = s.addr;
            next_b.wdata = s.wdata;
            next_b.st = EBPS_ADDR;
          end
        end
        EBPS_ADDR: begin
          // address phase always one cycle, latch pulse rides on it
          next_b.st = EBPS_STRB;
          next_b.cnt = `EBPS_STB_CYC - `EBPS_CNT_ONE;
        end
        EBPS_STRB: begin
          if (b.cnt != `EBPS_CNT_ZERO) begin
            next_b.cnt = b.cnt - `EBPS_CNT_ONE;
          end else if (b.wt_s[1]) begin
            // sample read data together with the released wait
            if (!b.we) begin
              next_b.rdata = b.din_s2;
            end
            next_b.st = EBPS_RECV;
          end
        end
        EBPS_RECV: begin
          // strobes already high; report completion across
          next_b.done_tgl = ~b.done_tgl;
          next_b.st = EBPS_IDLE;
        end
      endcase
      // pins follow the state entered, so they change on the same edge
      next_b.rd_n = !(next_b.st == EBPS_STRB && !next_b.we);
      next_b.wr_n = !(next_b.st == EBPS_STRB && next_b.we && !next_b.bmode);
      // byte mode: one store strobe per written lane
      if (next_b.st == EBPS_STRB && next_b.we && next_b.bmode) begin
        next_b.store_n = ~next_b.lanes;
      end else begin
        next_b.store_n = 2'h3;
      end
      // single strobe mode: lane enables cover reads and writes
      if ((next_b.st == EBPS_ADDR || next_b.st == EBPS_STRB) && !next_b.bmode) begin
        next_b.lane_n = ~next_b.lanes;
      end else begin
        next_b.lane_n = 2'h3;
      end
      next_b.ale = next_b.st == EBPS_ADDR && next_b.mux;
      // area select held through address and strobe phases
      if (next_b.st == EBPS_ADDR || next_b.st == EBPS_STRB) begin
        next_b.sel_n = ~area_dec(next_b.area);
      end else begin
        next_b.sel_n = {NAREA{1'b1}};
      end
      // shared lines: address first, then write data
      next_b.aout = '0;
      next_b.dout = '0;
      next_b.doe = 1'b0;
      if (next_b.st == EBPS_ADDR || next_b.st == EBPS_STRB) begin
        next_b.aout = next_b.addr;
        if (next_b.mux) begin
          next_b.aout[`EBPS_MUX_W-1:0] = '0;
        end
      end
      if (next_b.st == EBPS_ADDR && next_b.mux) begin
        next_b.dout = next_b.addr[`EBPS_MUX_W-1:0];
        next_b.doe = 1'b1;
      end else if (next_b.st == EBPS_STRB && next_b.we) begin
        next_b.dout = next_b.wdata;
        next_b.doe = 1'b1;
      end
    end
  end

  always_ff @(posedge bus_clk or negedge brst_n) begin
    if (!brst_n) begin
      b <= '{st: EBPS_IDLE, rd_n: 1'b1, wr_n: 1'b1, store_n: 2'h3, lane_n: 2'h3,
             sel_n: {NAREA{1'b1}}, wt_s: 2'h3, default: '0};
    end else begin
      b <= next_b;
    end
  end

  // outputs
  assign ready = !s.busy;
  assign done = s.done;
  assign rdata = s.rdata;
  assign ext_bus_clock_out = bus_clk;
  assign rd_n = b.rd_n;
  assign wr_n = b.wr_n;
  assign low_lane_store_strobe_n = b.store_n[`EBPS_LANE_LO];
  assign high_lane_store_strobe_n = b.store_n[`EBPS_LANE_HI];
  assign low_lane_enable_n = b.lane_n[`EBPS_LANE_LO];
  assign high_lane_enable_n = b.lane_n[`EBPS_LANE_HI];
  assign ale = b.ale;
  assign area_select_n = b.sel_n;
  assign addr_out = b.aout;
  assign data_out = b.dout;
  assign data_oe = b.doe;

  // checks on the pins

  // read strobe only in a read, with its area selected and the write strobe high
  rd_strobe_a: assert property (@(posedge bus_clk) disable iff (!brst_n)
    !rd_n |-> !b.we && !area_select_n[b.area] && wr_n)
    else $error("read strobe outside a read");

  // single write strobe never together with byte strobes
  wr_single_a: assert property (@(posedge bus_clk) disable iff (!brst_n)
    $fell(wr_n) |-> b.we && !b.bmode && low_lane_store_strobe_n
      && high_lane_store_strobe_n)
    else $error("single write strobe in wrong mode");

  // a byte store strobe marks exactly its own requested lane
  byte_strobe_a: assert property (@(posedge bus_clk) disable iff (!brst_n)
    (!low_lane_store_strobe_n || !high_lane_store_strobe_n) |->
      b.bmode && b.we && wr_n
      && {high_lane_store_strobe_n, low_lane_store_strobe_n} == ~b.lanes)
    else $error("byte store strobe mismatch");

  // lane enables match the requested lanes on the cycle after the latch pulse in single strobe mode
  lane_enable_a: assert property (@(posedge bus_clk) disable iff (!brst_n)
    (!b.bmode && $fell(ale) && b.en_s[1]) |->
      {high_lane_enable_n, low_lane_enable_n} == ~b.lanes)
    else $error("lane enables missing during access");

  // latch pulse lasts one cycle, carries the address and precedes data
  addr_latch_a: assert property (@(posedge bus_clk) disable iff (!brst_n)
    ale |-> data_oe && data_out == b.addr[`EBPS_MUX_W-1:0] ##1 (!ale || !b.en_s[1]))
    else $error("address latch pulse wrong");

  // a held wait keeps the read or write strobe active
  wait_hold_a: assert property (@(posedge bus_clk) disable iff (!brst_n)
    (b.st == EBPS_STRB && b.cnt == `EBPS_CNT_ZERO && !b.wt_s[1] && b.en_s[1])
      |=> b.st == EBPS_STRB && (!rd_n || !wr_n || b.bmode))
    else $error("access ended during wait request");

  // at most one area select low, and it is the addressed one
  area_one_a: assert property (@(posedge bus_clk) disable iff (!brst_n)
    area_select_n != {NAREA{1'b1}} |-> $onehot(~area_select_n)
      && !area_select_n[b.area])
    else $error("area select not one-hot");

  // strobe phase follows the address phase with the upper address held
  addr_first_a: assert property (@(posedge bus_clk) disable iff (!brst_n)
    (b.st == EBPS_ADDR && b.en_s[1]) |=>
      b.st == EBPS_STRB && addr_out[AW-1:`EBPS_MUX_W] == b.addr[AW-1:`EBPS_MUX_W]
      && (!b.mux || addr_out[`EBPS_MUX_W-1:0] == '0))
    else $error("address phase order broken");

  // system side answers only after a request was taken
  done_busy_a: assert property (@(posedge clk) disable iff (!srst_n)
    done |-> $past(s.busy))
    else $error("completion without request");

endmodule

// file: verif/ebps_ext_mem.sv
// far-side memory model: answers reads and asks for wait states
module ebps_ext_mem (
  input wire logic bclk,
  input wire logic rd_n,
  input wire logic ale,
  input wire logic [7:0] sel_n,
  input wire logic [23:0] addr_out,
  input wire logic [15:0] data_out,
  input wire logic [3:0] wait_len,
  output logic [15:0] data_in,
  output logic wait_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] lat = 16'h0; // address taken from the shared lines
  logic [3:0] cnt = 4'h0; // bus cycles since a select went low
  logic [15:0] last = 16'h0; // last value this model drove
  wire sel = ~&sel_n;
  // capture the address on the latch pulse, forget it between accesses
  always @(posedge bclk) begin
    if (ale) lat <= data_out;
    else if (!sel) lat <= 16'h0;
    cnt <= sel ? cnt + 4'h1 : 4'h0;
    if (!rd_n && sel) last <= data_in;
  end
  // read data only while the strobe is low; released lines show the inverse
  // so a design that samples too late cannot get lucky
  always_comb begin
    data_in = (!rd_n && sel) ? ((addr_out[15:0] | lat) ^ 16'hA5C3) : ~last;
    wait_n = !(sel && cnt < wait_len);
  end
endmodule

// file: verif/tb.sv
// testbench: random accesses against a reference, pins watched each bus cycle
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, bus_clk = 0, resetn = 0, en = 1, req = 0, req_we = 0;
  logic byte_strobe_mode = 0, mux_mode = 0;
  logic [23:0] req_addr = 24'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [1:0] req_lanes = 2'h0;
  logic [2:0] req_area = 3'h0;
  logic [3:0] wait_len = 4'h0; // wait cycles the far side asks for
  logic ready, done, ext_bus_clock_out, rd_n, wr_n, ale, wait_n, data_oe;
  logic low_lane_store_strobe_n, high_lane_store_strobe_n;
  logic low_lane_enable_n, high_lane_enable_n;
  logic [7:0] area_select_n;
  logic [23:0] addr_out;
  logic [15:0] rdata, data_out, data_in;
  logic [15:0] last_rd = 16'h0; // reference copy of the last read result
  logic [31:0] rng = 32'h0000005F;
  int error_cnt = 0, compares = 0;
  int sc, rc, wc, lc, hc, lec, hec, selc, alec; // per-access pin counts
  ebps_core dut_u (.clk(clk), .resetn(resetn), .en(en), .bus_clk(bus_clk), .req(req),
    .ready(ready), .req_we(req_we), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lanes(req_lanes), .req_area(req_area), .byte_strobe_mode(byte_strobe_mode),
    .mux_mode(mux_mode), .done(done), .rdata(rdata), .ext_bus_clock_out(ext_bus_clock_out),
    .rd_n(rd_n), .wr_n(wr_n), .low_lane_store_strobe_n(low_lane_store_strobe_n),
    .high_lane_store_strobe_n(high_lane_store_strobe_n),
    .low_lane_enable_n(low_lane_enable_n), .high_lane_enable_n(high_lane_enable_n),
    .ale(ale), .wait_n(wait_n), .area_select_n(area_select_n), .addr_out(addr_out),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  ebps_ext_mem mem_u (.bclk(ext_bus_clock_out), .rd_n(rd_n), .ale(ale), .sel_n(area_select_n),
    .addr_out(addr_out), .data_out(data_out), .wait_len(wait_len), .data_in(data_in),
    .wait_n(wait_n));
  // system clock and an unrelated link clock
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    #7;
    forever #62.5 bus_clk = ~bus_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // pin monitor, mid bus cycle where registered outputs have settled
  always @(negedge ext_bus_clock_out) if (~&area_select_n) begin
    selc++;
    `CHK(area_select_n, ~(8'h1 << req_area), "area select")
    if (ale) begin
      alec++;
      `CHK({data_oe, data_out}, {1'b1, req_addr[15:0]}, "latched address")
    end
    lec += int'(!low_lane_enable_n);
    hec += int'(!high_lane_enable_n);
    rc += int'(!rd_n);
    wc += int'(!wr_n);
    lc += int'(!low_lane_store_strobe_n);
    hc += int'(!high_lane_store_strobe_n);
    if (!rd_n || !wr_n || !low_lane_store_strobe_n || !high_lane_store_strobe_n) begin
      sc++;
      `CHK(addr_out, mux_mode ? {req_addr[23:16], 16'h0} : req_addr, "address")
      `CHK({data_oe, data_out}, {req_we, req_we ? req_wdata : 16'h0}, "data lines")
    end
  end
  // one access with random fields; waits for done under a bound
  task automatic access(input int i);
    int n;
    @(negedge clk);
    rng = xs(rng);
    {sc, rc, wc, lc, hc, lec, hec, selc, alec} = '0;
    req_addr = rng[23:0];
    req_wdata = rng[31:16];
    req_lanes = rng[9:8];
    mux_mode = rng[12];
    wait_len = rng[5] ? 4'h5 : 4'h0;
    req_area = i[2:0];
    req_we = i[3];
    byte_strobe_mode = i[4];
    req = 1;
    @(negedge clk);
    req = 0;
    for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk);
    `CHK(done, 1'b1, "access finished")
    `CHK((sc == 0) ? (req_we && byte_strobe_mode && req_lanes == 2'b00) :
      ((wait_len == 0) == (sc == 3)), 1'b1, "strobe length")
    `CHK(rc, req_we ? 0 : sc, "read strobe")
    `CHK(wc, (req_we && !byte_strobe_mode) ? sc : 0, "write strobe")
    `CHK(lc, (req_we && byte_strobe_mode && req_lanes[0]) ? sc : 0, "low store")
    `CHK(hc, (req_we && byte_strobe_mode && req_lanes[1]) ? sc : 0, "high store")
    `CHK(lec, (!byte_strobe_mode && req_lanes[0]) ? selc : 0, "low enable")
    `CHK(hec, (!byte_strobe_mode && req_lanes[1]) ? selc : 0, "high enable")
    `CHK(alec, int'(mux_mode), "latch pulse")
    if (!req_we) last_rd = req_addr[15:0] ^ 16'hA5C3;
    `CHK(rdata, last_rd, "read data")
  endtask
  task automatic complete_run();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence: reset, let both domains leave reset, then all areas in both directions and both strobe modes
  initial begin
    repeat (8) @(negedge clk);
    resetn = 1;
    repeat (30) @(negedge clk);
    `CHK(ext_bus_clock_out, bus_clk, "bus clock pin")
    `CHK(ready, 1'b1, "idle after reset")
    for (int i = 0; i < 32; i++) access(i);
    // a request while frozen must not be taken
    @(negedge clk);
    en = 0;
    req = 1;
    repeat (5) @(negedge clk);
    `CHK({ready, done}, 2'b10, "frozen request ignored")
    req = 0;
    en = 1;
    complete_run();
  end
  // hang guard, well past 32 slow accesses
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
endmodule
